// ==== common/smst_pkg.sv ====
// Constants, field layout and carrier types of the SMBus status block.
// Assumes a 32-bit APB register bus and a separate SMBus engine clock.
package smst_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map
   localparam logic [11:0] STATUS_OFFS   = 12'h424;
   localparam int          APB_AW        = 12;
   localparam int          BUS_ADDR_W    = 7;
   localparam int          SLV_ADDR_LSB  = 1;
   localparam int          MST_ADDR_LSB  = 9;
   localparam int          LOAD_DONE_BIT = 24;
   localparam int          NACK_BIT      = 25;
   localparam int          ARB_BIT       = 26;
   localparam int          MISP_BIT      = 27;
   localparam int          CSUM_BIT      = 28;
   localparam int          UNMAP_BIT     = 29;
   localparam int          W1C_LANE      = 3;
   localparam logic [31:0] STATUS_RESET  = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // Counts
   localparam int          ARB_LIMIT     = 16;
   localparam logic [1:0]  STRAP_SETTLE  = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic nack;
      logic arb_lost;
      logic arb_won;
      logic misplaced;
   } smst_link_evt_t;

   typedef struct packed {
      logic nack;
      logic arb;
      logic misp;
   } smst_tgl_t;

   typedef struct packed {
      logic load_done;
      logic csum_bad;
      logic no_done_cmd;
      logic unmapped;
   } smst_init_evt_t;

   typedef enum logic [1:0] {
      SMST_ST_RESET  = 2'b00,
      SMST_ST_SAMPLE = 2'b01,
      SMST_ST_RUN    = 2'b10
   } smst_state_t;

endpackage : smst_pkg

// ==== hdl/smst_link.sv ====
// Link-side logic: arbitration retry counting and event toggles.
// Assumes link_clk is the SMBus engine clock and that events are
// one-cycle pulses on that clock.
`timescale 1ns/1ps
module smst_link #(
   parameter int ARB_LIMIT = smst_pkg::ARB_LIMIT
) (
   input  wire logic                     link_clk,
   input  wire logic                     presetn,
   input  wire smst_pkg::smst_link_evt_t link_evt,
   output logic                          arb_retry,
   output logic                          txn_abort,
   output smst_pkg::smst_tgl_t           evt_tgl
);

   localparam int CW   = $clog2(ARB_LIMIT);
   localparam int LIM1 = ARB_LIMIT - 1;

   typedef struct packed {
      logic [1:0]          rst_sync;
      logic [CW-1:0]       lose_cnt;
      logic                retry;
      logic                abort;
      smst_pkg::smst_tgl_t tgl;
   } smst_link_st_t;

   smst_link_st_t s_ff;
   smst_link_st_t nxt_s;

   ////////////////////////////////////////////////////////////////////////////
   // Next state; held idle until the local reset release has settled
   always_comb begin
      nxt_s          = s_ff;
      nxt_s.rst_sync = {s_ff.rst_sync[0], 1'b1};
      nxt_s.retry    = 1'b0;
      nxt_s.abort    = 1'b0;
      if (s_ff.rst_sync[1]) begin
         if (link_evt.nack) begin
            nxt_s.tgl.nack = ~s_ff.tgl.nack;
         end
         if (link_evt.misplaced) begin
            nxt_s.tgl.misp = ~s_ff.tgl.misp;
         end
         // A won arbitration ends the run of consecutive losses
         if (link_evt.arb_won) begin
            nxt_s.lose_cnt = '0;
         end else if (link_evt.arb_lost) begin
            if (s_ff.lose_cnt == CW'(LIM1)) begin
               nxt_s.abort    = 1'b1;
               nxt_s.lose_cnt = '0;
               nxt_s.tgl.arb  = ~s_ff.tgl.arb;
            end else begin
               nxt_s.retry    = 1'b1;
               nxt_s.lose_cnt = s_ff.lose_cnt + CW'(1);
            end
         end
      end
   end

   // State register; toggles survive a stopped link clock
   always_ff @(posedge link_clk or negedge presetn) begin
      if (!presetn) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign arb_retry = s_ff.retry;
   assign txn_abort = s_ff.abort;
   assign evt_tgl   = s_ff.tgl;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge link_clk); endclocking
   default disable iff (!presetn);

   sequence s_last_loss;
      s_ff.rst_sync[1] && link_evt.arb_lost && !link_evt.arb_won
         && s_ff.lose_cnt == CW'(LIM1);
   endsequence

   sequence s_early_loss;
      s_ff.rst_sync[1] && link_evt.arb_lost && !link_evt.arb_won
         && s_ff.lose_cnt != CW'(LIM1);
   endsequence

   property p_retry;
      s_early_loss |=> arb_retry && !txn_abort;
   endproperty
   a_retry: assert property (p_retry) else $error("loss not retried");

   property p_abort;
      s_last_loss |=> txn_abort && !arb_retry && s_ff.lose_cnt == '0
         && evt_tgl.arb != $past(evt_tgl.arb);
   endproperty
   a_abort: assert property (p_abort) else $error("no abort at limit");

   property p_abort_cause;
      txn_abort |-> $past(s_ff.lose_cnt) == CW'(LIM1);
   endproperty
   a_abort_cause: assert property (p_abort_cause) else $error("early abort");

endmodule : smst_link

// ==== hdl/smst_top.sv ====
// SMBus status register block with APB slave and link-side event path.
// Assumes straps are stable pins, init events are pclk pulses and the
// SMBus engine runs on its own link_clk.
//
// Behaviour
// - Read-only slave address field, bits 7:1
// - Read-only master address field, bits 15:9
// - Load-complete flag on load end or error
// - Sticky flag on unexpected master NACK
// - Lost arbitration retried without software
// - Sixteen losses abort and set flag
// - Flag misplaced START or STOP condition
// - Flag bad configuration checksum
// - Same flag when done command missing
// - Flag load into nonexistent register
`timescale 1ns/1ps
module smst_top #(
   parameter int AW        = smst_pkg::APB_AW,
   parameter int ARB_LIMIT = smst_pkg::ARB_LIMIT
) (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [AW-1:0]               paddr,
   input  wire logic [31:0]                 pwdata,
   input  wire logic [3:0]                  pstrb,
   output logic [31:0]                      prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic [smst_pkg::BUS_ADDR_W-1:0] slave_addr_pins,
   input  wire logic [smst_pkg::BUS_ADDR_W-1:0] master_addr_pins,
   input  wire logic                        load_mode,
   input  wire smst_pkg::smst_init_evt_t    init_evt,
   input  wire logic                        link_clk,
   input  wire smst_pkg::smst_link_evt_t    link_evt,
   output logic                             arb_retry,
   output logic                             txn_abort
);

   localparam int AdW = smst_pkg::BUS_ADDR_W;

   typedef struct packed {
      smst_pkg::smst_state_t        st;
      logic [1:0]                   strap_cnt;
      logic [2:0][2*AdW-1:0]        strap_sync;
      logic [AdW-1:0]               s_addr;
      logic [AdW-1:0]               m_addr;
      logic [2:0][2:0]              tsync;
      smst_pkg::smst_tgl_t          tlast;
      logic                         load_done;
      logic                         nack;
      logic                         arb;
      logic                         misp;
      logic                         csum;
      logic                         unmap;
      logic [31:0]                  prdata;
      logic                         pready;
      logic                         pslverr;
   } smst_st_t;

   smst_st_t            s_ff;
   smst_st_t            nxt_s;
   smst_pkg::smst_tgl_t evt_tgl;
   smst_pkg::smst_tgl_t agree;
   smst_pkg::smst_tgl_t ev;
   logic [31:0]         clr;
   logic                hit;
   logic                setup;
   logic                access;
   logic                err_in;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic smst_hit(input logic [AW-1:0] a);
      return a == AW'(smst_pkg::STATUS_OFFS);
   endfunction : smst_hit

   // Only defined fields are placed; everything else stays zero
   function automatic logic [31:0] smst_word(input smst_st_t s);
      logic [31:0] w;
      w = smst_pkg::STATUS_RESET;
      w[smst_pkg::SLV_ADDR_LSB +: AdW] = s.s_addr;
      w[smst_pkg::MST_ADDR_LSB +: AdW] = s.m_addr;
      w[smst_pkg::LOAD_DONE_BIT]       = s.load_done;
      w[smst_pkg::NACK_BIT]            = s.nack;
      w[smst_pkg::ARB_BIT]             = s.arb;
      w[smst_pkg::MISP_BIT]            = s.misp;
      w[smst_pkg::CSUM_BIT]            = s.csum;
      w[smst_pkg::UNMAP_BIT]           = s.unmap;
      return w;
   endfunction : smst_word

   ////////////////////////////////////////////////////////////////////////////
   // Link domain
   smst_link #(
      .ARB_LIMIT (ARB_LIMIT)
   ) u_link (
      .link_clk  (link_clk),
      .presetn   (presetn),
      .link_evt  (link_evt),
      .arb_retry (arb_retry),
      .txn_abort (txn_abort),
      .evt_tgl   (evt_tgl)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state of the core side
   always_comb begin
      nxt_s  = s_ff;
      setup  = psel && !penable;
      access = psel && penable && s_ff.pready;
      hit    = smst_hit(paddr);
      // Toggle crossing: a change counts once stages two and three agree
      nxt_s.tsync = {s_ff.tsync[1], s_ff.tsync[0], evt_tgl};
      agree       = ~(s_ff.tsync[1] ^ s_ff.tsync[2]);
      ev          = agree & (s_ff.tsync[2] ^ s_ff.tlast);
      nxt_s.tlast = (s_ff.tlast & ~agree) | (s_ff.tsync[2] & agree);
      // Straps pass three stages, then latch once after reset release
      nxt_s.strap_sync = {s_ff.strap_sync[1], s_ff.strap_sync[0],
                          {master_addr_pins, slave_addr_pins}};
      case (s_ff.st)
         smst_pkg::SMST_ST_RESET: begin
            nxt_s.st        = smst_pkg::SMST_ST_SAMPLE;
            nxt_s.strap_cnt = '0;
         end
         smst_pkg::SMST_ST_SAMPLE: begin
            if (s_ff.strap_cnt != smst_pkg::STRAP_SETTLE) begin
               nxt_s.strap_cnt = s_ff.strap_cnt + 2'h1;
            end else if (s_ff.strap_sync[1] == s_ff.strap_sync[2]) begin
               nxt_s.s_addr = s_ff.strap_sync[2][AdW-1:0];
               nxt_s.m_addr = s_ff.strap_sync[2][2*AdW-1:AdW];
               nxt_s.st     = smst_pkg::SMST_ST_RUN;
            end
         end
         smst_pkg::SMST_ST_RUN: begin
            nxt_s.st = smst_pkg::SMST_ST_RUN;
         end
         default: begin
            nxt_s.st = smst_pkg::SMST_ST_RESET;
         end
      endcase
      // Write-one-to-clear only through the strobed top byte lane
      clr = '0;
      if (access && pwrite && hit && pstrb[smst_pkg::W1C_LANE]) begin
         clr = pwdata;
      end
      // Sticky flags; a set in the clearing cycle wins
      err_in = init_evt.csum_bad || init_evt.no_done_cmd || init_evt.unmapped;
      nxt_s.nack  = (s_ff.nack & ~clr[smst_pkg::NACK_BIT]) | ev.nack;
      nxt_s.arb   = (s_ff.arb & ~clr[smst_pkg::ARB_BIT]) | ev.arb;
      nxt_s.misp  = (s_ff.misp & ~clr[smst_pkg::MISP_BIT]) | ev.misp;
      nxt_s.csum  = (s_ff.csum & ~clr[smst_pkg::CSUM_BIT])
                    | init_evt.csum_bad
                    | init_evt.no_done_cmd;
      nxt_s.unmap = (s_ff.unmap & ~clr[smst_pkg::UNMAP_BIT])
                    | init_evt.unmapped;
      // Completion is read-only and holds until the next reset
      if (load_mode && (init_evt.load_done || err_in)) begin
         nxt_s.load_done = 1'b1;
      end
      // Zero-wait APB: answer is prepared in the setup cycle
      nxt_s.pready  = setup;
      nxt_s.pslverr = setup && !hit;
      if (setup) begin
         nxt_s.prdata = (hit && !pwrite) ? smst_word(s_ff) : '0;
      end
   end

   // Core state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign prdata  = s_ff.prdata;
   assign pready  = s_ff.pready;
   assign pslverr = s_ff.pslverr;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_rd_done;
      psel && penable && pready && !pwrite && !pslverr;
   endsequence

   sequence s_w1c(int b);
      psel && penable && pready && pwrite && hit
         && pstrb[smst_pkg::W1C_LANE] && pwdata[b];
   endsequence

   property p_slv_addr;
      (s_rd_done and (s_ff.st == smst_pkg::SMST_ST_RUN
         && $past(s_ff.st) == smst_pkg::SMST_ST_RUN))
         |-> prdata[smst_pkg::SLV_ADDR_LSB +: AdW] == s_ff.s_addr;
   endproperty
   a_slv_addr: assert property (p_slv_addr) else $error("slave addr");

   property p_mst_addr;
      s_ff.st == smst_pkg::SMST_ST_RUN |=> $stable(s_ff.m_addr)
         && s_ff.st == smst_pkg::SMST_ST_RUN;
   endproperty
   a_mst_addr: assert property (p_mst_addr) else $error("master addr");

   property p_done;
      load_mode && init_evt.load_done |=> s_ff.load_done [*2];
   endproperty
   a_done: assert property (p_done) else $error("load done");

   property p_done_cause;
      $rose(s_ff.load_done) |-> $past(load_mode);
   endproperty
   a_done_cause: assert property (p_done_cause) else $error("done cause");

   property p_nack;
      ev.nack |=> s_ff.nack;
   endproperty
   a_nack: assert property (p_nack) else $error("nack flag");

   property p_arb;
      ev.arb |=> s_ff.arb;
   endproperty
   a_arb: assert property (p_arb) else $error("arb flag");

   property p_misp;
      $rose(s_ff.misp) |-> $past(ev.misp);
   endproperty
   a_misp: assert property (p_misp) else $error("misplaced flag");

   property p_csum;
      init_evt.csum_bad |=> s_ff.csum;
   endproperty
   a_csum: assert property (p_csum) else $error("checksum flag");

   property p_nodone;
      init_evt.no_done_cmd |=> s_ff.csum;
   endproperty
   a_nodone: assert property (p_nodone) else $error("done cmd flag");

   property p_unmap;
      init_evt.unmapped |=> s_ff.unmap;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped flag");

   property p_clear;
      (s_w1c(smst_pkg::UNMAP_BIT) and !init_evt.unmapped) |=> !s_ff.unmap;
   endproperty
   a_clear: assert property (p_clear) else $error("w1c failed");

   property p_keep;
      s_ff.nack && !(psel && penable && pready && pwrite && hit
         && pstrb[smst_pkg::W1C_LANE] && pwdata[smst_pkg::NACK_BIT]) |=> s_ff.nack;
   endproperty
   a_keep: assert property (p_keep) else $error("flag lost");

   property p_rsvd;
      s_rd_done |-> prdata[0] == 1'b0 && prdata[8] == 1'b0
         && prdata[23:16] == 8'h00 && prdata[31:30] == 2'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits");

   property p_pready;
      psel && !penable |=> pready ##1 !pready;
   endproperty
   a_pready: assert property (p_pready) else $error("pready timing");

endmodule : smst_top

// ==== verif/smst_link_model.sv ====
// Behavioural SMBus engine model: gated link clock and event pulses.
// Assumes the block samples link_evt on the rising link_clk edge.
`timescale 1ns/1ps
module smst_link_model (
   output logic                     link_clk,
   output smst_pkg::smst_link_evt_t link_evt,
   input  wire logic                arb_retry,
   input  wire logic                txn_abort
);
   int n_retry;
   int n_abort;

   ////////////////////////////////////////////////////////////////////////////
   // Clock stands still low outside frames, as a real engine would
   initial begin
      link_clk = 1'b0;
      link_evt = '0;
      n_retry  = 0;
      n_abort  = 0;
   end

   // Count the block's answers; reads pre-edge values, so no race
   always @(posedge link_clk) begin
      if (arb_retry === 1'b1) n_retry++;
      if (txn_abort === 1'b1) n_abort++;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Idle link clock cycles within a frame
   task automatic tick(input int n);
      repeat (n) begin
         #62.5 link_clk = 1'b1;
         #62.5 link_clk = 1'b0;
      end
   endtask : tick

   // One event pulse, one link_clk wide, then trailing clocks for the answer
   task automatic send(input smst_pkg::smst_link_evt_t e);
      #62.5 link_clk = 1'b1;
      link_evt <= e;
      #62.5 link_clk = 1'b0;
      #62.5 link_clk = 1'b1;
      link_evt <= '0;
      #62.5 link_clk = 1'b0;
      tick(2);
   endtask : send
endmodule : smst_link_model

// ==== verif/test_smbus_master_status.sv ====
// Self-checking bench for the SMBus status block over APB.
// Assumes the engine model on the link side; APB waits for pready.
`timescale 1ns/1ps
module test_smbus_master_status;
   logic        pclk, presetn, psel, penable, pwrite, load_mode;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, exp_st;
   logic [3:0]  pstrb;
   logic        pready, pslverr, arb_retry, txn_abort, link_clk;
   logic [6:0]  slv, mst;
   smst_pkg::smst_init_evt_t init_evt;
   smst_pkg::smst_link_evt_t link_evt;
   logic [32:0] exp_q[$];
   logic [31:0] msk_q[$];
   int          n_mismatch = 0;
   int          samples_checked = 0;
   localparam int IBIT [4] = '{24, 28, 28, 29};

   smst_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .slave_addr_pins(slv), .master_addr_pins(mst),
      .load_mode(load_mode), .init_evt(init_evt), .link_clk(link_clk),
      .link_evt(link_evt), .arb_retry(arb_retry), .txn_abort(txn_abort));
   smst_link_model u_eng (.link_clk(link_clk), .link_evt(link_evt),
      .arb_retry(arb_retry), .txn_abort(txn_abort));

   ////////////////////////////////////////////////////////////////////////////
   // Core clock, 8 ns period
   initial pclk = 1'b0;
   always #4 pclk = ~pclk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict

   // Watcher: every completed access takes the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
         check(prdata & msk_q[0], exp_q[0][31:0] & msk_q[0]);
         check({31'h0, pslverr}, {31'h0, exp_q[0][32]});
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB master; starts on a rising edge, holds until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [31:0] m, input logic er);
      // An unmapped access reads back zero together with the error flag
      exp_q.push_back(er ? {1'b1, 32'h0} : {1'b0, exp_st});
      msk_q.push_back(m);
      // Callers may return off the core edge, e.g. after link activity
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // No cycle count assumed; only the watchdog ends a stuck wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd();
      apb(1'b0, smst_pkg::STATUS_OFFS, 32'h0, 4'h0, 32'hFFFFFFFF, 1'b0);
   endtask : rd

   task automatic wr(input logic [31:0] d, input logic [3:0] s);
      apb(1'b1, smst_pkg::STATUS_OFFS, d, s, 32'h0, 1'b0);
   endtask : wr

   // Five core clocks of reset with fresh straps, then wait out both syncs
   task automatic do_reset();
      presetn <= 1'b0;
      slv <= 7'($urandom());
      mst <= 7'($urandom());
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      // Link side needs two of its own edges before it takes events
      u_eng.tick(3);
      repeat (10) @(posedge pclk);
      exp_st = {16'h0, mst, 1'b0, slv, 1'b0};
   endtask : do_reset

   task automatic pulse_init(input smst_pkg::smst_init_evt_t e);
      init_evt <= e;
      @(posedge pclk);
      init_evt <= '0;
      repeat (2) @(posedge pclk);
   endtask : pulse_init

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog; the run needs about 20 us, so 200 us means a hang
   initial begin
      #200000;
      n_mismatch++;
      give_verdict();
   end

   // Main sequence
   initial begin
      // Starts high so that the first reset is a true falling edge
      presetn = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = '0;
      load_mode = 1'b0;
      init_evt = '0;
      exp_st = '0;
      void'($urandom(32'h2cbbb8b6));
      do_reset();
      rd();
      wr(32'hFFFFFFFF, 4'hF);
      rd();
      apb(1'b0, 12'h400 + 12'($urandom_range(0, 8) * 4), 32'h0, 4'h0, 32'hFFFFFFFF, 1'b1);
      $display("test strap and reserved done");
      // Load-complete needs load mode
      pulse_init(smst_pkg::smst_init_evt_t'(4'h8));
      rd();
      load_mode <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         pulse_init(smst_pkg::smst_init_evt_t'(4'h8 >> i));
         exp_st[24] = 1'b1;
         exp_st[IBIT[i]] = 1'b1;
         rd();
         wr(32'h1 << IBIT[i], 4'hF);
         exp_st[IBIT[i]] = (i == 0);
         rd();
      end
      $display("test init events done");
      u_eng.send(smst_pkg::smst_link_evt_t'(4'h8));
      exp_st[25] = 1'b1;
      rd();
      wr(32'h0, 4'hF);
      rd();
      wr(32'hFFFFFFFF, 4'h7);
      rd();
      wr($urandom() & ~32'h02000000, 4'hF);
      rd();
      wr(32'h02000000, 4'h8);
      exp_st[25] = 1'b0;
      rd();
      u_eng.send(smst_pkg::smst_link_evt_t'(4'h1));
      exp_st[27] = 1'b1;
      rd();
      $display("test nack and misplaced done");
      // A win in the middle restarts the loss count
      repeat (10) u_eng.send(smst_pkg::smst_link_evt_t'(4'h4));
      u_eng.send(smst_pkg::smst_link_evt_t'(4'h2));
      repeat (15) u_eng.send(smst_pkg::smst_link_evt_t'(4'h4));
      rd();
      check(u_eng.n_abort, 32'd0);
      u_eng.send(smst_pkg::smst_link_evt_t'(4'h4));
      check(u_eng.n_retry, 32'd25);
      check(u_eng.n_abort, 32'd1);
      exp_st[26] = 1'b1;
      rd();
      wr(32'h0C000000, 4'hF);
      exp_st[27:26] = 2'b00;
      rd();
      $display("test arbitration done");
      pulse_init(smst_pkg::smst_init_evt_t'(4'h1));
      do_reset();
      rd();
      $display("test second reset done");
      give_verdict();
   end
endmodule : test_smbus_master_status
